// File: pdbist_params.svh
`ifndef PDBIST_PARAMS_SVH
`define PDBIST_PARAMS_SVH

// Request type codes, bits 31..28 of the test data object
`define PDB_REQ_RX      4'h0
`define PDB_REQ_TX      4'h1
`define PDB_REQ_RC      4'h2
`define PDB_REQ_CAR0    4'h3
`define PDB_REQ_CAR1    4'h4
`define PDB_REQ_CAR2    4'h5
`define PDB_REQ_CAR3    4'h6
`define PDB_REQ_EYE     4'h7
`define PDB_REQ_TDATA   4'h8

// Field widths of the test data object
`define PDB_REQ_W       4
`define PDB_RSVD_W      12
`define PDB_CNT_W       16

// Clock rate and link timing (times in microseconds)
`define PDB_CLK_MHZ     40
`define PDB_T_MODE_US   200
`define PDB_T_RESP_US   1000
`define PDB_T_ERRTMR_US 800
`define PDB_TMR_W       20

// Local pattern generator
`define PDB_PRBS_W      9
`define PDB_PRBS_TAP    5
`define PDB_PRBS_SEED   9'h1FF
`define PDB_CAR3_W      5

`endif

// File: pdbist_pkg.sv
package pdbist_pkg;
  `include "pdbist_params.svh"

  // Test mode the port is in
  typedef enum logic [3:0] {
    MD_IDLE, MD_RX, MD_TX, MD_CAR0, MD_CAR1, MD_CAR2, MD_CAR3, MD_EYE, MD_TDATA
  } pdbist_mode_e;

  // Test data object layout
  typedef struct packed {
    logic [`PDB_REQ_W-1:0]  req;
    logic [`PDB_RSVD_W-1:0] rsvd;
    logic [`PDB_CNT_W-1:0]  count;
  } pdbist_bdo_s;

  // Whole state of the handler
  typedef struct packed {
    pdbist_mode_e            mode;
    logic [`PDB_CNT_W-1:0]   err;
    logic [`PDB_PRBS_W-1:0]  prbs;
    logic [`PDB_CAR3_W-1:0]  pat;
    logic [`PDB_TMR_W-1:0]   tmr;
    logic                    first;
    logic                    gcrc;
    logic                    resp;
    logic                    start;
    logic                    tx_bit;
    pdbist_bdo_s             bdo;
  } pdbist_state_s;
endpackage : pdbist_pkg

// File: pdbist_test_mode.sv
`timescale 1ns/1ps
module pdbist_test_mode
  import pdbist_pkg::*;
#(
  parameter int T_MODE_US   = `PDB_T_MODE_US,
  parameter int T_RESP_US   = `PDB_T_RESP_US,
  parameter int T_ERRTMR_US = `PDB_T_ERRTMR_US
) (
  input  wire logic                   mclk_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   vsafe5v_i,
  input  wire logic                   contract_i,
  input  wire logic                   hard_reset_i,
  input  wire logic                   bist_valid_i,
  input  wire pdbist_bdo_s            bist_bdo_i,
  input  wire logic                   msg_rx_i,
  input  wire logic                   gcrc_done_i,
  input  wire logic                   rx_bit_valid_i,
  input  wire logic                   rx_bit_i,
  input  wire logic                   rx_frame_end_i,
  input  wire logic                   phy_bit_en_i,
  output logic                        goodcrc_req_o,
  output logic                        resp_valid_o,
  output pdbist_bdo_s                 resp_bdo_o,
  output logic                        frame_start_o,
  output logic                        frame_mode_o,
  output logic                        cont_tx_o,
  output logic                        tx_bit_o,
  output pdbist_mode_e                mode_o,
  output logic [`PDB_CNT_W-1:0]       test_error_count_o
);

  // Longest times round down to whole cycles
  localparam int MODE_CYC   = T_MODE_US * `PDB_CLK_MHZ;
  localparam int RESP_CYC   = T_RESP_US * `PDB_CLK_MHZ;
  localparam int ERRTMR_CYC = T_ERRTMR_US * `PDB_CLK_MHZ;
  localparam logic [`PDB_TMR_W-1:0] MODE_LIM = `PDB_TMR_W'(MODE_CYC - 1);
  localparam logic [`PDB_TMR_W-1:0] ERR_LIM  = `PDB_TMR_W'(ERRTMR_CYC - 1);

  // The error timer alone must keep frames inside the response limit
  if (MODE_CYC < 2 || ERRTMR_CYC < 2 || ERRTMR_CYC > RESP_CYC) begin : g_bad_timing
    $error("pdbist_test_mode: timing parameters out of range");
  end
  // Timer saturates at all ones, so the limit must fit below that
  if (RESP_CYC >= (1 << `PDB_TMR_W)) begin : g_bad_timer
    $error("pdbist_test_mode: timer too narrow for response limit");
  end

  // One step of the local PRBS; new bit enters at the bottom
  function automatic logic [`PDB_PRBS_W-1:0] prbs_step(input logic [`PDB_PRBS_W-1:0] p);
    logic fb;
    fb = p[`PDB_PRBS_W-1] ^ p[`PDB_PRBS_TAP-1];
    return {p[`PDB_PRBS_W-2:0], fb};
  endfunction : prbs_step

  pdbist_state_s state;
  pdbist_state_s next_state;
  logic          req_ok;
  logic          in_band;

  // Supply and contract gate every request
  assign req_ok  = bist_valid_i & vsafe5v_i & contract_i;
  // Only idle, receiver and transmit states act on requests and hard reset
  assign in_band = (state.mode == MD_IDLE) || (state.mode == MD_RX) ||
                   (state.mode == MD_TX);

  // Next state
  always_comb begin
    next_state       = state;
    next_state.gcrc  = 1'b0;
    next_state.resp  = 1'b0;
    next_state.start = 1'b0;

    case (state.mode)
      // Receiver test: check frame bits against local PRBS
      MD_RX: begin
        if (rx_bit_valid_i) begin
          if (rx_bit_i != state.prbs[`PDB_PRBS_W-1] && state.err != '1) begin
            next_state.err = state.err + 16'h0001;
          end
          next_state.prbs = prbs_step(state.prbs);
        end
        // Frames may come at any spacing; each answered unless hard reset or a receive, carrier, eye or test data request comes too
        if (rx_frame_end_i) begin
          next_state.resp        = 1'b1;
          next_state.bdo.req     = `PDB_REQ_RC;
          next_state.bdo.rsvd    = '0;
          next_state.bdo.count   = next_state.err;
        end
      end
      // Transmit test: frame scheduling and PRBS bits
      MD_TX: begin
        if (state.tmr != '1) begin
          next_state.tmr = state.tmr + 1'b1;
        end
        if (state.first) begin
          // First frame after the GoodCRC, or at the latest limit
          if (gcrc_done_i || state.tmr >= MODE_LIM) begin
            next_state.start = 1'b1;
            next_state.first = 1'b0;
            next_state.tmr   = '0;
          end
        end else if (state.tmr >= ERR_LIM) begin
          next_state.start = 1'b1;
          next_state.tmr   = '0;
        end
        if (phy_bit_en_i) begin
          next_state.tx_bit = state.prbs[`PDB_PRBS_W-1];
          next_state.prbs   = prbs_step(state.prbs);
        end
      end
      MD_CAR0: begin
        if (phy_bit_en_i) begin
          next_state.tx_bit = 1'b0;
        end
      end
      MD_CAR1: begin
        if (phy_bit_en_i) begin
          next_state.tx_bit = 1'b1;
        end
      end
      MD_CAR2: begin
        if (phy_bit_en_i) begin
          next_state.tx_bit = ~state.tx_bit;
        end
      end
      MD_CAR3: begin
        // Top counter bit splits the 32-bit period in halves
        if (phy_bit_en_i) begin
          next_state.tx_bit = ~state.pat[`PDB_CAR3_W-1];
          next_state.pat    = state.pat + 1'b1;
        end
      end
      MD_EYE: begin
        if (phy_bit_en_i) begin
          next_state.tx_bit = state.prbs[`PDB_PRBS_W-1];
          next_state.prbs   = prbs_step(state.prbs);
        end
      end
      MD_TDATA: begin
        // Nothing but GoodCRC leaves the port from here on
        if (msg_rx_i) begin
          next_state.gcrc = 1'b1;
        end
      end
      default: begin
      end
    endcase

    // Requests; carrier, eye and test data states never leave in band
    if (in_band) begin
      if (hard_reset_i) begin
        next_state.mode  = MD_IDLE;
        next_state.tmr   = '0;
        next_state.first = 1'b0;
        next_state.resp  = 1'b0;
        next_state.start = 1'b0;
      end else if (req_ok) begin
        case (bist_bdo_i.req)
          `PDB_REQ_RX: begin
            next_state.mode = MD_RX;
            next_state.err  = '0;
            next_state.prbs = `PDB_PRBS_SEED;
            next_state.resp = 1'b0;
            next_state.gcrc = 1'b1;
          end
          `PDB_REQ_TX: begin
            // Tester is expected to be ready already
            next_state.mode  = MD_TX;
            next_state.prbs  = `PDB_PRBS_SEED;
            next_state.first = 1'b1;
            next_state.tmr   = '0;
            next_state.start = 1'b0;
            next_state.gcrc  = 1'b1;
          end
          `PDB_REQ_RC: begin
            // Message id not checked during frame exchange
            next_state.gcrc = 1'b1;
            if (state.mode == MD_TX && !state.first) begin
              next_state.start = 1'b1;
              next_state.tmr   = '0;
            end
          end
          `PDB_REQ_CAR0, `PDB_REQ_CAR1, `PDB_REQ_CAR2, `PDB_REQ_CAR3,
          `PDB_REQ_EYE: begin
            case (bist_bdo_i.req)
              `PDB_REQ_CAR0: next_state.mode = MD_CAR0;
              `PDB_REQ_CAR1: next_state.mode = MD_CAR1;
              `PDB_REQ_CAR2: next_state.mode = MD_CAR2;
              `PDB_REQ_CAR3: next_state.mode = MD_CAR3;
              default:       next_state.mode = MD_EYE;
            endcase
            next_state.prbs   = `PDB_PRBS_SEED;
            next_state.pat    = '0;
            next_state.tx_bit = 1'b0;
            next_state.resp   = 1'b0;
            next_state.start  = 1'b0;
            next_state.gcrc   = 1'b1;
          end
          `PDB_REQ_TDATA: begin
            next_state.mode  = MD_TDATA;
            next_state.resp  = 1'b0;
            next_state.start = 1'b0;
            next_state.gcrc  = 1'b1;
          end
          default: begin
            // Reserved codes are dropped without reply
          end
        endcase
      end
    end
  end

  // State register; only a power-up style reset leaves the fixed modes
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= '{mode: MD_IDLE, prbs: `PDB_PRBS_SEED, default: '0};
    end else begin
      state <= next_state;
    end
  end

  // Outputs straight from the state register
  assign goodcrc_req_o      = state.gcrc;
  assign resp_valid_o       = state.resp;
  assign resp_bdo_o         = state.bdo;
  assign frame_start_o      = state.start;
  assign frame_mode_o       = (state.mode == MD_TX);
  assign cont_tx_o          = (state.mode == MD_CAR0) || (state.mode == MD_CAR1) ||
                              (state.mode == MD_CAR2) || (state.mode == MD_CAR3) ||
                              (state.mode == MD_EYE);
  assign tx_bit_o           = state.tx_bit;
  assign mode_o             = state.mode;
  assign test_error_count_o = state.err;

endmodule : pdbist_test_mode

// File: pdbist_test_mode_monitor.sv
`timescale 1ns/1ps
module pdbist_test_mode_monitor
  import pdbist_pkg::*;
#(
  parameter int T_MODE_US = 1,
  parameter int T_RESP_US = 2
) (
  input wire logic         mclk_i,
  input wire logic         rst_n_i,
  input wire logic         vsafe5v_i,
  input wire logic         contract_i,
  input wire logic         hard_reset_i,
  input wire logic         bist_valid_i,
  input wire pdbist_bdo_s  bist_bdo_i,
  input wire logic         rx_bit_valid_i,
  input wire logic         rx_frame_end_i,
  input wire logic         goodcrc_req_o,
  input wire logic         resp_valid_o,
  input wire pdbist_bdo_s  resp_bdo_o,
  input wire logic         frame_start_o,
  input wire logic         frame_mode_o,
  input wire pdbist_mode_e mode_o,
  input wire logic [15:0]  test_error_count_o
);
  // Limits in 40 MHz cycles; one spare for the registered start pulse
  localparam int MODE_LIM = T_MODE_US * 40 + 1;
  localparam int RESP_LIM = T_RESP_US * 40;
  logic take;
  // Request that must be accepted
  assign take = bist_valid_i && vsafe5v_i && contract_i && !hard_reset_i
    && bist_bdo_i.req <= 4'h8 && mode_o inside {MD_IDLE, MD_RX, MD_TX};
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // Request handling and receiver test
  a_req_ack: assert property (take |=> goodcrc_req_o)
    else $error("request not acknowledged");
  a_rx_clear: assert property (take && bist_bdo_i.req == 4'h0 |=> mode_o == MD_RX
    && test_error_count_o == 16'h0) else $error("receiver entry wrong");
  a_rx_answer: assert property (mode_o == MD_RX && rx_frame_end_i && !hard_reset_i
    && !bist_valid_i |=> resp_valid_o && resp_bdo_o == {4'h2, 12'h000, test_error_count_o})
    else $error("frame answer wrong");
  a_count_hold: assert property (mode_o == MD_RX && !rx_bit_valid_i && !bist_valid_i
    && !hard_reset_i |=> $stable(test_error_count_o)) else $error("count moved without bit");
  a_hard_exit: assert property (hard_reset_i && mode_o inside {MD_RX, MD_TX}
    |=> mode_o == MD_IDLE) else $error("hard reset ignored");
  // Continuous and test-data modes are left only by the port reset
  a_mode_lock: assert property (mode_o >= MD_CAR0 |=> $stable(mode_o))
    else $error("locked mode left");
  a_first_frame: assert property ($rose(frame_mode_o) |-> ##[0:MODE_LIM]
    (frame_start_o || !frame_mode_o)) else $error("first frame late");
  a_next_frame: assert property (frame_start_o |=> ##[0:RESP_LIM]
    (frame_start_o || !frame_mode_o)) else $error("next frame late");
endmodule : pdbist_test_mode_monitor

bind pdbist_test_mode pdbist_test_mode_monitor #(
  .T_MODE_US(T_MODE_US), .T_RESP_US(T_RESP_US)
) pdbist_test_mode_monitor_inst (
  .mclk_i, .rst_n_i, .vsafe5v_i, .contract_i, .hard_reset_i, .bist_valid_i, .bist_bdo_i,
  .rx_bit_valid_i, .rx_frame_end_i, .goodcrc_req_o, .resp_valid_o, .resp_bdo_o,
  .frame_start_o, .frame_mode_o, .mode_o, .test_error_count_o
);

// File: pdbist_tester.sv
`timescale 1ns/1ps
module pdbist_tester (
  input  wire logic mclk_i,
  output logic      rx_bit_valid_o,
  output logic      rx_bit_o,
  output logic      rx_frame_end_o,
  output logic      hard_reset_o
);
  logic [8:0] prbs;
  int         errs;
  // Idle link at time zero
  initial begin
    {rx_bit_valid_o, rx_bit_o, rx_frame_end_o, hard_reset_o} = 4'h0;
    preload();
  end
  // Tally cleared and generator reseeded before each accepted receive, transmit and continuous mode request
  task automatic preload();
    prbs = 9'h1FF;
    errs = 0;
  endtask : preload
  // Pattern bit, then advance; also checks transmitted frames
  function automatic logic step();
    step = prbs[8];
    prbs = {prbs[7:0], prbs[8] ^ prbs[4]};
  endfunction : step
  // Payload with chosen bits inverted; line toggles once released
  task automatic send_frame(input int n, input logic [31:0] flip);
    for (int i = 0; i < n; i++) begin
      @(negedge mclk_i);
      rx_bit_valid_o = 1'b1;
      rx_bit_o       = step() ^ flip[i];
      errs           = errs + int'(flip[i]);
    end
    @(negedge mclk_i);
    {rx_bit_valid_o, rx_bit_o, rx_frame_end_o} = {1'b0, ~rx_bit_o, 1'b1};
    @(negedge mclk_i);
    rx_frame_end_o = 1'b0;
  endtask : send_frame
  // Only way this side ends a receive or transmit test
  task automatic hard_reset();
    @(negedge mclk_i);
    hard_reset_o = 1'b1;
    @(negedge mclk_i);
    hard_reset_o = 1'b0;
  endtask : hard_reset
endmodule : pdbist_tester

// File: tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module tb_top
  import pdbist_pkg::*;
;
  logic         mclk_i, rst_n_i, vsafe5v_i, contract_i, bist_valid_i, msg_rx_i;
  logic         gcrc_done_i, phy_bit_en_i, hard_reset_i, rx_bit_valid_i, rx_bit_i;
  logic         rx_frame_end_i, goodcrc_req_o, resp_valid_o, frame_start_o;
  logic         frame_mode_o, cont_tx_o, tx_bit_o;
  logic [15:0]  test_error_count_o;
  logic [32:0]  want;
  pdbist_bdo_s  bist_bdo_i, resp_bdo_o;
  pdbist_mode_e mode_o;
  int           miscompares, n_checks, seed;
  // Short timers keep the run brief
  pdbist_test_mode #(.T_MODE_US(1), .T_RESP_US(2), .T_ERRTMR_US(1)) pdbist_test_mode_inst (
    .mclk_i, .rst_n_i, .vsafe5v_i, .contract_i, .hard_reset_i, .bist_valid_i, .bist_bdo_i,
    .msg_rx_i, .gcrc_done_i, .rx_bit_valid_i, .rx_bit_i, .rx_frame_end_i, .phy_bit_en_i,
    .goodcrc_req_o, .resp_valid_o, .resp_bdo_o, .frame_start_o, .frame_mode_o, .cont_tx_o,
    .tx_bit_o, .mode_o, .test_error_count_o);
  pdbist_tester pdbist_tester_inst (.mclk_i, .rx_bit_valid_o(rx_bit_valid_i),
    .rx_bit_o(rx_bit_i), .rx_frame_end_o(rx_frame_end_i), .hard_reset_o(hard_reset_i));
  // 40 MHz clock and hang guard
  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  initial begin
    repeat (4000) @(posedge mclk_i);
    miscompares++;
    close_out();
  end
  task automatic pulse(ref logic s);
    @(negedge mclk_i);
    s = 1'b1;
    @(negedge mclk_i);
    s = 1'b0;
  endtask : pulse
  task automatic reset_dut();
    @(negedge mclk_i);
    rst_n_i = 1'b0;
    repeat (5) @(negedge mclk_i);
    rst_n_i = 1'b1;
    `CHK("idle", {MD_IDLE, 16'h0000}, {mode_o, test_error_count_o})
  endtask : reset_dut
  // Object randomised once qualifier released
  task automatic req(input logic [3:0] code, input logic ack);
    @(negedge mclk_i);
    {bist_valid_i, bist_bdo_i} = {1'b1, code, 28'h0};
    @(negedge mclk_i);
    {bist_valid_i, bist_bdo_i} = {1'b0, $random(seed)};
    `CHK("ack", ack, goodcrc_req_o)
  endtask : req
  // Expected stream per mode; PRBS modes follow the tester generator
  task automatic run_bits(input logic [3:0] c, input int n);
    logic e;
    for (int i = 0; i < n; i++) begin
      pulse(phy_bit_en_i);
      e = (c == 3) ? 1'b0 : (c == 4) ? 1'b1 : (c == 5) ? ~i[0] : (c == 6) ? ~i[4]
        : pdbist_tester_inst.step();
      `CHK("tx bit", e, tx_bit_o)
    end
  endtask : run_bits
  task automatic close_out();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out
  // Scenarios; inputs change on the falling edge
  initial begin
    {rst_n_i, bist_valid_i, msg_rx_i, gcrc_done_i, phy_bit_en_i} = 5'h00;
    {vsafe5v_i, contract_i, bist_bdo_i} = {2'h3, 32'h0};
    {miscompares, n_checks, seed} = {32'h0, 32'h0, 32'hB8F5};
    reset_dut();
    vsafe5v_i = 1'b0;
    req(4'h0, 1'b0);
    {vsafe5v_i, contract_i} = 2'b10;
    req(4'h1, 1'b0);
    contract_i = 1'b1;
    for (int c = 9; c < 16; c++) req(4'(c), 1'b0);
    pdbist_tester_inst.preload();
    req(4'h0, 1'b1);
    `CHK("count", 16'h0000, test_error_count_o)
    repeat (2) begin
      repeat (2 + $unsigned($random(seed)) % 6) @(negedge mclk_i);
      pdbist_tester_inst.send_frame(24, $random(seed));
      want = {1'b1, 4'h2, 12'h000, 16'(pdbist_tester_inst.errs)};
      `CHK("resp", want, {resp_valid_o, resp_bdo_o})
    end
    pdbist_tester_inst.hard_reset();
    `CHK("mode", MD_IDLE, mode_o)
    pdbist_tester_inst.preload();
    req(4'h1, 1'b1);
    `CHK("tx mode", 1'b1, frame_mode_o)
    pulse(gcrc_done_i);
    `CHK("frame", 1'b1, frame_start_o)
    run_bits(4'h1, 8);
    req(4'h2, 1'b1);
    `CHK("frame", 1'b1, frame_start_o)
    pdbist_tester_inst.hard_reset();
    `CHK("mode", MD_IDLE, mode_o)
    // Each continuous mode; in-band traffic must not end it
    for (int c = 3; c < 8; c++) begin
      reset_dut();
      pdbist_tester_inst.preload();
      req(4'(c), 1'b1);
      `CHK("cont", 1'b1, cont_tx_o)
      run_bits(4'(c), 40);
      pdbist_tester_inst.hard_reset();
      req(4'h0, 1'b0);
      `CHK("mode", pdbist_mode_e'(c), mode_o)
    end
    reset_dut();
    req(4'h8, 1'b1);
    pulse(msg_rx_i);
    `CHK("gcrc", 1'b1, goodcrc_req_o)
    req(4'h1, 1'b0);
    close_out();
  end
endmodule : tb_top
